/* File: src/ckp_pkg.sv */
// package: register map, field positions, reset values and timing constants
package ckp_pkg;
	// ================================================================
	// register map (printed offsets 0x04, 0x05 are not word multiples)
	localparam logic [3:0]  IDX_CTRL2    = 4'h4;
	localparam logic [3:0]  IDX_PWR      = 4'h5;
	localparam logic [3:0]  IDX_IRQ_STAT = 4'h8;
	localparam logic [3:0]  IDX_IRQ_EN   = 4'h9;
	localparam logic [3:0]  IDX_IRQ_CLR  = 4'hA;
	localparam logic [3:0]  IDX_STATUS   = 4'hB;
	localparam logic [3:0]  IDX_CFG      = 4'hC;
	// ================================================================
	// control two field positions
	localparam int TRIG_BIT   = 15;
	localparam int AMP_LSB    = 12;
	localparam int ISTEP_BIT  = 11;
	localparam int TONE_LSB   = 8;
	localparam int DUR_LSB    = 4;
	localparam int LSET_BIT   = 3;
	localparam int RSET_BIT   = 2;
	localparam int PSTEP_BIT  = 1;
	localparam int ISET_BIT   = 0;
	// ================================================================
	// reset values
	localparam logic [2:0]  AMP_RST   = 3'h4;
	localparam logic [2:0]  TONE_RST  = 3'h4;
	localparam logic [3:0]  DUR_RST   = 4'h1;
	localparam logic [9:0]  PWR_RST   = 10'h3FF;
	localparam logic [9:0]  PWR_ALL   = 10'h3FF;
	localparam logic [6:0]  GAIN_RST  = 7'h00;
	// ================================================================
	// power field positions
	localparam int PWR_LSB    = 6;
	localparam int PDAC_IDX   = 4;
	localparam int PADC_IDX   = 3;
	localparam int PSIDE_IDX  = 7;
	localparam int RDONE_BIT  = 5;
	localparam int LDONE_BIT  = 4;
	localparam int RGDONE_BIT = 3;
	localparam int SDONE_BIT  = 2;
	// ================================================================
	// timing: 250 MHz core clock
	localparam int  CLK_HZ      = 250_000_000;
	localparam int  TONE_MAX_HZ = 8000;
	// half period at 8 kHz, in cycles; code c scales by 2**(7-c)
	localparam int  HALF_BASE   = CLK_HZ / (2 * TONE_MAX_HZ);
	localparam int  SETTLE_NS   = 1000;
	localparam int  SETTLE_CYC  = (SETTLE_NS * 250 + 999) / 1000;
	localparam int  SAT_GAIN    = 24;
	// ================================================================
	// interrupt events
	localparam int  EV_CLICK    = 0;
	localparam int  EV_ISET     = 1;
	localparam int  EV_PSET     = 2;
	localparam int  EV_PWR      = 3;
	localparam int  NEV         = 4;
	typedef enum logic [1:0] {CK_IDLE, CK_HIGH, CK_LOW} ckp_click_e;
endpackage

/* File: src/ckp_gain_stepper.sv */
// one soft-stepped gain channel paced by a word strobe
`timescale 1ns/1ps
module ckp_gain_stepper (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// pacing
	input  wire logic       wordStrobe,
	input  wire logic       stepRate,
	// gain
	input  wire logic [6:0] target,
	output logic      [6:0] applied,
	output logic            settled
);
	logic halfPhase;
	wire  stepNow = wordStrobe && (!stepRate || halfPhase);
	wire  atGoal  = applied == target;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			halfPhase <= 1'b0;
			applied   <= ckp_pkg::GAIN_RST;
			settled   <= 1'b1;
		end else begin
			if (wordStrobe)
				halfPhase <= !halfPhase;
			if (stepNow && !atGoal)
				applied <= (applied < target) ? applied + 7'h01 : applied - 7'h01;
			settled <= atGoal;
		end
	end
endmodule

/* File: src/ckp_click_gen.sv */
// click tone generator: square tone, whole periods, amplitude scaled
`timescale 1ns/1ps
module ckp_click_gen (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// control
	input  wire logic       start,
	input  wire logic [2:0] ampSel,
	input  wire logic [2:0] toneSel,
	input  wire logic [3:0] durSel,
	// output
	output logic      [7:0] sample,
	output logic            busy,
	output logic            done
);
	ckp_pkg::ckp_click_e state;
	logic [22:0] halfCnt;
	logic [5:0]  periods;
	wire  [22:0] halfLen = 23'(ckp_pkg::HALF_BASE) << (3'h7 - toneSel);
	wire  [5:0]  perLen  = {1'b0, durSel, 1'b0} + 6'h02;
	wire         halfEnd = halfCnt == halfLen - 23'h000001;
	wire  [7:0]  level   = {1'b0, ampSel, 4'hF};
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state   <= ckp_pkg::CK_IDLE;
			halfCnt <= 23'h000000;
			periods <= 6'h00;
			sample  <= 8'h00;
			busy    <= 1'b0;
			done    <= 1'b0;
		end else begin
			done    <= 1'b0;
			halfCnt <= halfEnd ? 23'h000000 : halfCnt + 23'h000001;
			case (state)
			ckp_pkg::CK_IDLE: begin
				halfCnt <= 23'h000000;
				periods <= 6'h00;
				sample  <= 8'h00;
				if (start) begin
					state  <= ckp_pkg::CK_HIGH;
					busy   <= 1'b1;
					sample <= level;
				end
			end
			ckp_pkg::CK_HIGH: if (halfEnd) begin
				state  <= ckp_pkg::CK_LOW;
				sample <= 8'h00 - level;
			end
			ckp_pkg::CK_LOW: if (halfEnd) begin
				if (periods == perLen - 6'h01) begin
					state  <= ckp_pkg::CK_IDLE;
					sample <= 8'h00;
					busy   <= 1'b0;
					done   <= 1'b1;
				end else begin
					periods <= periods + 6'h01;
					state   <= ckp_pkg::CK_HIGH;
					sample  <= level;
				end
			end
			default: state <= ckp_pkg::CK_IDLE;
			endcase
		end
	end
endmodule

/* File: src/ckp_ctrl.sv */
// click, soft-step and power control register bank with apb slave
//
// Functional notes
// - trigger starts burst, then clears itself
// - amplitude code scales click, reset 100
// - tone code doubles 62.5 Hz to 8 kHz
// - burst is two times code plus two periods
// - input gain steps per strobe or two
// - under agc step bit reads noise flag
// - left/right playback settled flags read only
// - playback gain steps per strobe or two
// - input gain settled flag read only
// - under agc input flag reports saturation
// - ten power bits, 1 powers down, reset 1
// - record converter off-done flag, reset 1
// - playback left/right off-done flags
// - sidetone off-done flag, reset 1
// - all ten set means codec fully down
`timescale 1ns/1ps
module ckp_ctrl (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// word strobes and agc status
	input  wire logic        record_word_strobe,
	input  wire logic        play_word_strobe,
	input  wire logic        agcEnable,
	input  wire logic        belowNoise,
	input  wire logic [6:0]  inputTarget,
	input  wire logic [6:0]  leftTarget,
	input  wire logic [6:0]  rightTarget,
	// analog controls, click sample and interrupt
	output logic      [9:0]  powerOff,
	output logic             codecAllOff,
	output logic      [7:0]  clickSample,
	output logic             irq
);
	// ================================================================
	// registers
	logic        click_trigger;
	logic [2:0]  click_amplitude_sel;
	logic        input_gain_step_rate;
	logic [2:0]  click_tone_sel;
	logic [3:0]  click_duration_sel;
	logic        playback_gain_step_rate;
	logic [9:0]  pwrBits;
	logic [3:0]  offDone;
	logic [ckp_pkg::NEV-1:0] irqStat;
	logic [ckp_pkg::NEV-1:0] irqEn;
	logic [15:0] settleCnt [3:0];
	logic        clickStarted;
	// ================================================================
	// apb decode
	wire  [3:0]  regIdx   = paddr[5:2];
	wire         addrOk   = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0);
	wire         selCtrl2 = addrOk && regIdx == ckp_pkg::IDX_CTRL2;
	wire         selPwr   = addrOk && regIdx == ckp_pkg::IDX_PWR;
	wire         selStat  = addrOk && regIdx == ckp_pkg::IDX_IRQ_STAT;
	wire         selEn    = addrOk && regIdx == ckp_pkg::IDX_IRQ_EN;
	wire         selClr   = addrOk && regIdx == ckp_pkg::IDX_IRQ_CLR;
	wire         selSts   = addrOk && regIdx == ckp_pkg::IDX_STATUS;
	wire         mapped   = selCtrl2 | selPwr | selStat | selEn | selClr | selSts;
	wire         access   = psel && penable && !pready;
	wire         wrStb    = psel && penable && pready && pwrite && mapped;
	wire         wrCtrl2  = wrStb && selCtrl2;
	wire         wrPwr    = wrStb && selPwr;
	// ================================================================
	// gain steppers
	logic [6:0]  inputApplied;
	logic [6:0]  leftApplied;
	logic        input_gain_settled;
	logic        left_gain_settled;
	logic        right_gain_settled;
	ckp_gain_stepper uInGain (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.wordStrobe (record_word_strobe),
		.stepRate   (input_gain_step_rate),
		.target     (inputTarget),
		.applied    (inputApplied),
		.settled    (input_gain_settled)
	);
	ckp_gain_stepper uLeftGain (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.wordStrobe (play_word_strobe),
		.stepRate   (playback_gain_step_rate),
		.target     (leftTarget),
		.applied    (leftApplied),
		.settled    (left_gain_settled)
	);
	ckp_gain_stepper uRightGain (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.wordStrobe (play_word_strobe),
		.stepRate   (playback_gain_step_rate),
		.target     (rightTarget),
		.applied    (),
		.settled    (right_gain_settled)
	);
	// ================================================================
	// click generator
	logic        clickBusy;
	logic        clickDone;
	logic [7:0]  clickOut;
	wire         clickStart = click_trigger && !clickBusy && !clickStarted;
	ckp_click_gen uClick (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.start    (clickStart),
		.ampSel   (click_amplitude_sel),
		.toneSel  (click_tone_sel),
		.durSel   (click_duration_sel),
		.sample   (clickOut),
		.busy     (clickBusy),
		.done     (clickDone)
	);
	// ================================================================
	// agc views of shared bits
	wire         saturated = inputApplied >= 7'(ckp_pkg::SAT_GAIN);
	wire         stepRead  = agcEnable ? belowNoise : input_gain_step_rate;
	wire         isetRead  = agcEnable ? saturated : input_gain_settled;
	wire  [15:0] ctrl2Read = {click_trigger, click_amplitude_sel, stepRead,
		click_tone_sel, click_duration_sel, left_gain_settled, right_gain_settled,
		playback_gain_step_rate, isetRead};
	wire  [15:0] pwrRead   = {pwrBits, offDone, 2'h0};
	wire  [15:0] stsRead   = {13'h0000, clickBusy, codecAllOff, irq};
	wire  [31:0] rdMux     = selCtrl2 ? {16'h0000, ctrl2Read} :
		selPwr  ? {16'h0000, pwrRead} :
		selStat ? {28'h0000000, irqStat} :
		selEn   ? {28'h0000000, irqEn} :
		selSts  ? {16'h0000, stsRead} : 32'h00000000;
	// ================================================================
	// off-done tracking: each section settles after a fixed delay
	// index 3 record conv, 2 left, 1 right, 0 sidetone
	wire  [3:0]  offReq = {pwrBits[ckp_pkg::PADC_IDX], pwrBits[ckp_pkg::PDAC_IDX],
		pwrBits[ckp_pkg::PDAC_IDX], pwrBits[ckp_pkg::PSIDE_IDX]};
	wire  [3:0]  offHit;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gOff
			assign offHit[g] = offReq[g] && !offDone[g] &&
				settleCnt[g] == 16'(ckp_pkg::SETTLE_CYC);
			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					settleCnt[g] <= 16'h0000;
					offDone[g]   <= 1'b1;
				end else if (!offReq[g]) begin
					settleCnt[g] <= 16'h0000;
					offDone[g]   <= 1'b0;
				end else if (!offDone[g]) begin
					settleCnt[g] <= settleCnt[g] + 16'h0001;
					offDone[g]   <= offHit[g];
				end
			end
		end
	endgenerate
	// ================================================================
	// interrupt events
	logic        isetPrev;
	logic        psetPrev;
	wire         psetNow = left_gain_settled && right_gain_settled;
	wire  [ckp_pkg::NEV-1:0] events = {|offHit, psetNow && !psetPrev,
		input_gain_settled && !isetPrev, clickDone};
	wire  [ckp_pkg::NEV-1:0] clrMask = (wrStb && selClr) ?
		pwdata[ckp_pkg::NEV-1:0] : '0;
	// ================================================================
	// register updates
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			click_trigger           <= 1'b0;
			click_amplitude_sel     <= ckp_pkg::AMP_RST;
			input_gain_step_rate    <= 1'b0;
			click_tone_sel          <= ckp_pkg::TONE_RST;
			click_duration_sel      <= ckp_pkg::DUR_RST;
			playback_gain_step_rate <= 1'b0;
			pwrBits                 <= ckp_pkg::PWR_RST;
			clickStarted            <= 1'b0;
		end else begin
			if (clickStart)
				clickStarted <= 1'b1;
			if (wrCtrl2) begin
				click_trigger           <= pwdata[ckp_pkg::TRIG_BIT];
				click_amplitude_sel     <= pwdata[ckp_pkg::AMP_LSB +: 3];
				click_tone_sel          <= pwdata[ckp_pkg::TONE_LSB +: 3];
				click_duration_sel      <= pwdata[ckp_pkg::DUR_LSB +: 4];
				playback_gain_step_rate <= pwdata[ckp_pkg::PSTEP_BIT];
				if (!agcEnable)
					input_gain_step_rate <= pwdata[ckp_pkg::ISTEP_BIT];
			end
			if (clickDone) begin
				click_trigger <= 1'b0;
				clickStarted  <= 1'b0;
			end
			if (wrPwr)
				pwrBits <= pwdata[ckp_pkg::PWR_LSB +: 10];
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irqStat  <= '0;
			irqEn    <= '0;
			isetPrev <= 1'b1;
			psetPrev <= 1'b1;
		end else begin
			irqStat  <= (irqStat & ~clrMask) | events;
			isetPrev <= input_gain_settled;
			psetPrev <= psetNow;
			if (wrStb && selEn)
				irqEn <= pwdata[ckp_pkg::NEV-1:0];
		end
	end
	// ================================================================
	// bus answer and registered outputs
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata      <= 32'h00000000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			powerOff    <= ckp_pkg::PWR_RST;
			codecAllOff <= 1'b1;
			clickSample <= 8'h00;
			irq         <= 1'b0;
		end else begin
			pready      <= access;
			pslverr     <= access && !mapped;
			prdata      <= (access && !pwrite) ? rdMux : 32'h00000000;
			powerOff    <= pwrBits;
			codecAllOff <= pwrBits == ckp_pkg::PWR_ALL;
			clickSample <= clickOut;
			irq         <= |(irqStat & irqEn);
		end
	end
	// ================================================================
	// assertions
	AST_TRIG_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_b)
		clickDone |=> !click_trigger)
		else $error("trigger not cleared after burst");
	AST_ALL_OFF: assert property (@(posedge core_clk) disable iff (!rst_b)
		(pwrBits == 10'h3FF) |=> codecAllOff)
		else $error("codec not reported fully down");
	AST_PWR_OUT: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrPwr |=> ##1 (powerOff == $past(pwdata[15:6], 2)))
		else $error("power bits not driven out");
	AST_STEP_RO: assert property (@(posedge core_clk) disable iff (!rst_b)
		(wrCtrl2 && agcEnable) |=> $stable(input_gain_step_rate))
		else $error("step bit written under agc");
	AST_NOISE_READ: assert property (@(posedge core_clk) disable iff (!rst_b)
		(access && !pwrite && selCtrl2 && agcEnable) |=> prdata[11] == $past(belowNoise))
		else $error("noise flag not shown");
	AST_SAT_READ: assert property (@(posedge core_clk) disable iff (!rst_b)
		(access && !pwrite && selCtrl2 && agcEnable)
		|=> prdata[0] == ($past(inputApplied) >= 7'd24))
		else $error("saturation flag not shown");
	AST_SETTLED: assert property (@(posedge core_clk) disable iff (!rst_b)
		(leftTarget == 7'h00 && left_gain_settled) |-> ctrl2Read[3])
		else $error("left settled flag not shown");
	AST_DONE_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_b)
		!pwrBits[3] |=> !offDone[3])
		else $error("record off-done not cleared on power up");
	AST_BUSY_DONE: assert property (@(posedge core_clk) disable iff (!rst_b)
		clickDone |-> !clickBusy && clickOut == 8'h00 && $past(clickOut[7]))
		else $error("click ended off a period boundary");
	AST_TRIG_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
		(click_trigger && !clickDone && !wrCtrl2)
		|=> click_trigger)
		else $error("trigger dropped before burst end");
	AST_START_BUSY: assert property (@(posedge core_clk) disable iff (!rst_b)
		clickStart
		|=> clickBusy)
		else $error("trigger did not start a burst");
	AST_CLICK_HIGH: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(clickBusy)
		|-> clickOut == {1'b0, click_amplitude_sel, 4'hF})
		else $error("click high level wrong");
	AST_CLICK_LOW: assert property (@(posedge core_clk) disable iff (!rst_b)
		($rose(clickOut[7]) && clickBusy)
		|-> clickOut == 8'h00 - $past(clickOut))
		else $error("click low level wrong");
	AST_SAMPLE_IDLE: assert property (@(posedge core_clk) disable iff (!rst_b)
		!clickBusy
		|-> clickOut == 8'h00)
		else $error("click output not quiet when idle");
	AST_IN_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
		!record_word_strobe
		|=> $stable(inputApplied))
		else $error("input gain moved without strobe");
	AST_IN_FAST: assert property (@(posedge core_clk) disable iff (!rst_b)
		(record_word_strobe && !input_gain_step_rate && inputApplied < inputTarget)
		|=> inputApplied == $past(inputApplied) + 7'h01)
		else $error("input gain missed a step");
	AST_LEFT_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
		!play_word_strobe
		|=> $stable(leftApplied))
		else $error("left gain moved without strobe");
	AST_LEFT_FAST: assert property (@(posedge core_clk) disable iff (!rst_b)
		(play_word_strobe && !playback_gain_step_rate && leftApplied < leftTarget)
		|=> leftApplied == $past(leftApplied) + 7'h01)
		else $error("left gain missed a step");
	AST_READ_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_b)
		(access && !pwrite && selCtrl2)
		|=> prdata[3:2] == $past({left_gain_settled, right_gain_settled}))
		else $error("playback settled flags not read back");
	AST_ISET_READ: assert property (@(posedge core_clk) disable iff (!rst_b)
		(access && !pwrite && selCtrl2 && !agcEnable)
		|=> prdata[0] == $past(input_gain_settled))
		else $error("input settled flag not read back");
	AST_PWR_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
		!wrPwr
		|=> $stable(pwrBits))
		else $error("power bits changed without a write");
	AST_DONE_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(offDone[3])
		|-> $past(settleCnt[3]) == 16'(ckp_pkg::SETTLE_CYC))
		else $error("record off-done set early");
	AST_DAC_DONE: assert property (@(posedge core_clk) disable iff (!rst_b)
		!pwrBits[ckp_pkg::PDAC_IDX]
		|=> !offDone[2] && !offDone[1])
		else $error("playback off-done not cleared on power up");
	AST_SIDE_DONE: assert property (@(posedge core_clk) disable iff (!rst_b)
		!pwrBits[ckp_pkg::PSIDE_IDX]
		|=> !offDone[0])
		else $error("sidetone off-done not cleared on power up");
	AST_NOT_ALL: assert property (@(posedge core_clk) disable iff (!rst_b)
		(pwrBits != ckp_pkg::PWR_ALL)
		|=> !codecAllOff)
		else $error("codec reported down while a section is up");
	AST_READY_PULSE: assert property (@(posedge core_clk) disable iff (!rst_b)
		pready
		|=> !pready)
		else $error("ready held longer than one cycle");
	AST_ERR_READY: assert property (@(posedge core_clk) disable iff (!rst_b)
		pslverr
		|-> pready)
		else $error("error raised without ready");
endmodule

/* File: verif/test_codec_keyclick_softstep_power_ctrl.sv */
// self-checking bench for the click, soft-step and power register bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
module test_codec_keyclick_softstep_power_ctrl;
	// ================================================================
	// signals
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        record_word_strobe = 1'b0;
	logic        play_word_strobe = 1'b0;
	logic        agcEnable = 1'b0;
	logic        belowNoise = 1'b0;
	logic [6:0]  inputTarget = 7'h00;
	logic [6:0]  leftTarget = 7'h00;
	logic [6:0]  rightTarget = 7'h00;
	logic [9:0]  powerOff;
	logic        codecAllOff;
	logic [7:0]  clickSample;
	logic        irq;
	logic [31:0] rd;
	logic        er;
	logic [2:0]  amp = 3'h4;
	logic [2:0]  tone = 3'h4;
	logic [3:0]  dur = 4'h1;
	logic        istep = 1'b0;
	logic        pstep = 1'b0;
	logic [9:0]  pat;
	logic [7:0]  posv = 8'h00;
	logic [7:0]  negv = 8'h00;
	int          nz = 0;
	int          tests_run = 0;
	int          mismatches = 0;
	int          n1;
	int          n2;
	int          k;
	// ================================================================
	// clock, design
	always #2 core_clk = ~core_clk;
	ckp_ctrl u_ckp_ctrl (
		.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.record_word_strobe(record_word_strobe), .play_word_strobe(play_word_strobe),
		.agcEnable(agcEnable), .belowNoise(belowNoise), .inputTarget(inputTarget),
		.leftTarget(leftTarget), .rightTarget(rightTarget), .powerOff(powerOff),
		.codecAllOff(codecAllOff), .clickSample(clickSample), .irq(irq)
	);
	// ================================================================
	// click waveform monitor
	always @(posedge core_clk) begin
		if (clickSample !== 8'h00)
			nz <= nz + 1;
		if (clickSample[7] === 1'b0 && clickSample !== 8'h00)
			posv <= clickSample;
		if (clickSample[7] === 1'b1)
			negv <= clickSample;
	end
	// ================================================================
	// expectations
	function automatic logic [31:0] c2(input logic t);
		return {16'h0, t, amp, istep, tone, dur, 2'b00, pstep, 1'b0};
	endfunction
	function automatic logic [31:0] pw(input logic [9:0] p, input logic s);
		return {16'h0, p, p[ckp_pkg::PADC_IDX] & s, p[ckp_pkg::PDAC_IDX] & s,
			p[ckp_pkg::PDAC_IDX] & s, p[ckp_pkg::PSIDE_IDX] & s, 2'b00};
	endfunction
	function automatic int clen();
		return (2 * int'(dur) + 2) * 2 * (ckp_pkg::HALF_BASE << (7 - int'(tone)));
	endfunction
	// ================================================================
	// tasks
	task automatic close_out;
		$display("tests %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			mismatches++;
			close_out();
		end
	endtask
	task automatic pulse(input logic pl, input int n);
		repeat (n) begin
			@(posedge core_clk);
			if (pl)
				play_word_strobe <= 1'b1;
			else
				record_word_strobe <= 1'b1;
			@(posedge core_clk);
			play_word_strobe <= 1'b0;
			record_word_strobe <= 1'b0;
		end
		repeat (2) @(posedge core_clk);
	endtask
	// ================================================================
	// watchdog
	initial begin
		repeat (95000) @(posedge core_clk);
		mismatches++;
		close_out();
	end
	// ================================================================
	// main sequence
	initial begin
		k = $urandom(12);
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		// reset values and unmapped access
		`CHK("powerOff rst", ckp_pkg::PWR_RST, powerOff)
		`CHK("allOff rst", 1'b1, codecAllOff)
		apb(1'b0, 8'h10, 32'h0);
		`CHK("ctrl2 rst", 32'h4410, rd & 32'hFFFFFFF2)
		apb(1'b0, 8'h14, 32'h0);
		`CHK("power rst", pw(10'h3FF, 1'b1), rd)
		apb(1'b1, 8'h30, 32'hFFFF);
		`CHK("unmapped wr err", 1'b1, er)
		apb(1'b0, 8'h11, 32'h0);
		`CHK("misaligned err", 1'b1, er)
		`CHK("misaligned data", 32'h0, rd)
		apb(1'b0, 8'h2C, 32'h0);
		`CHK("status rst", 32'h00000002, rd)
		$display("test reset done");
		// power bits and done flags
		apb(1'b1, 8'h14, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		`CHK("power zero", pw(10'h000, 1'b0), rd)
		`CHK("allOff zero", 1'b0, codecAllOff)
		apb(1'b1, 8'h14, 32'hFFC0);
		apb(1'b0, 8'h14, 32'h0);
		`CHK("power pending", pw(10'h3FF, 1'b0), rd)
		`CHK("allOff full", 1'b1, codecAllOff)
		repeat (260) @(posedge core_clk);
		apb(1'b0, 8'h14, 32'h0);
		`CHK("power done", pw(10'h3FF, 1'b1), rd)
		repeat (4) begin
			pat = 10'($urandom);
			apb(1'b1, 8'h14, {16'h0, pat, 6'h0});
			repeat (260) @(posedge core_clk);
			apb(1'b0, 8'h14, 32'h0);
			`CHK("power rand", pw(pat, 1'b1), rd)
			`CHK("powerOff rand", pat, powerOff)
			`CHK("allOff rand", &pat, codecAllOff)
		end
		$display("test power done");
		// input gain stepping, both rates
		n1 = 3 + $urandom_range(5);
		n2 = 2 + $urandom_range(3);
		apb(1'b1, 8'h10, c2(1'b0));
		inputTarget <= 7'(n1);
		pulse(1'b0, n1 - 1);
		apb(1'b0, 8'h10, 32'h0);
		`CHK("input settling", 1'b0, rd[0])
		pulse(1'b0, 1);
		apb(1'b0, 8'h10, 32'h0);
		`CHK("input settled", 1'b1, rd[0])
		istep = 1'b1;
		apb(1'b1, 8'h10, c2(1'b0));
		inputTarget <= 7'(n1 + n2);
		pulse(1'b0, 2 * n2 - 2);
		apb(1'b0, 8'h10, 32'h0);
		`CHK("input slow settling", 1'b0, rd[0])
		pulse(1'b0, 2);
		apb(1'b0, 8'h10, 32'h0);
		`CHK("input slow settled", 1'b1, rd[0])
		// agc: saturation and noise flag
		agcEnable <= 1'b1;
		apb(1'b0, 8'h10, 32'h0);
		`CHK("not saturated", 1'b0, rd[0])
		agcEnable <= 1'b0;
		istep = 1'b0;
		apb(1'b1, 8'h10, c2(1'b0));
		inputTarget <= 7'd30;
		pulse(1'b0, 30 - n1 - n2);
		agcEnable <= 1'b1;
		apb(1'b0, 8'h10, 32'h0);
		`CHK("saturated", 1'b1, rd[0])
		repeat (4) begin
			belowNoise <= 1'($urandom);
			istep = 1'($urandom);
			apb(1'b1, 8'h10, c2(1'b0));
			apb(1'b0, 8'h10, 32'h0);
			`CHK("noise flag", belowNoise, rd[ckp_pkg::ISTEP_BIT])
		end
		agcEnable <= 1'b0;
		istep = 1'b0;
		$display("test input gain done");
		// playback gain, separate channels
		apb(1'b1, 8'h10, c2(1'b0));
		leftTarget <= 7'd3;
		rightTarget <= 7'd6;
		pulse(1'b1, 3);
		apb(1'b0, 8'h10, 32'h0);
		`CHK("left settled", 2'b10, rd[3:2])
		pulse(1'b1, 3);
		apb(1'b0, 8'h10, 32'h0);
		`CHK("both settled", 2'b11, rd[3:2])
		pstep = 1'b1;
		apb(1'b1, 8'h10, c2(1'b0));
		leftTarget <= 7'd7;
		pulse(1'b1, 6);
		apb(1'b0, 8'h10, 32'h0);
		`CHK("left slow", 2'b01, rd[3:2])
		pulse(1'b1, 2);
		apb(1'b0, 8'h10, 32'h0);
		`CHK("left slow done", 2'b11, rd[3:2])
		$display("test playback gain done");
		// click burst and interrupt
		apb(1'b1, 8'h28, 32'hF);
		apb(1'b1, 8'h24, 32'h1);
		amp = 3'($urandom_range(7));
		tone = 3'h7;
		dur = 4'h0;
		nz = 0;
		apb(1'b1, 8'h10, c2(1'b1));
		apb(1'b0, 8'h10, 32'h0);
		`CHK("trigger set", 1'b1, rd[ckp_pkg::TRIG_BIT])
		k = 0;
		do begin
			apb(1'b0, 8'h10, 32'h0);
			k++;
		end while (rd[ckp_pkg::TRIG_BIT] !== 1'b0 && k < 30000);
		`CHK("trigger cleared", 1'b0, rd[ckp_pkg::TRIG_BIT])
		`CHK("click length", 1'b1, nz >= clen() - 2 && nz <= clen() + 2)
		`CHK("click high", {1'b0, amp, 4'hF}, posv)
		`CHK("click low", 8'(-{1'b0, amp, 4'hF}), negv)
		`CHK("click idle", 8'h00, clickSample)
		apb(1'b0, 8'h20, 32'h0);
		`CHK("click event", 1'b1, rd[ckp_pkg::EV_CLICK])
		`CHK("irq on", 1'b1, irq)
		apb(1'b1, 8'h24, 32'h0);
		repeat (2) @(posedge core_clk);
		`CHK("irq masked", 1'b0, irq)
		apb(1'b1, 8'h24, 32'h1);
		repeat (2) @(posedge core_clk);
		`CHK("irq unmasked", 1'b1, irq)
		apb(1'b1, 8'h28, 32'h1);
		repeat (2) @(posedge core_clk);
		`CHK("irq cleared", 1'b0, irq)
		apb(1'b0, 8'h20, 32'h0);
		`CHK("event cleared", 1'b0, rd[ckp_pkg::EV_CLICK])
		$display("test click done");
		close_out();
	end
endmodule
